// file: dcfifo_pkg.sv
// Shared constants, carrier structs and enumerations for one FIFO bank
// with its pin-level status flags and a small AHB-Lite register slave.
// Assumes a single system clock; the pin clocks are sampled, not used as clocks.
`default_nettype none
package dcfifo_pkg;

  localparam int CLK_PERIOD_NS = 40;
  // Three sampling flops plus one filter stage before a strap level is trusted
  localparam logic [2:0] STRAP_WAIT_CYCLES = 3'h5;

  localparam int DEPTH_DEFAULT = 256;
  localparam int DATA_W        = 9;
  localparam int OFFSET_W      = 8;
  localparam int OFFSET_REGS   = 4;

  localparam logic [7:0] OFFSET_LSB_DEFAULT = 8'h07;
  localparam logic [7:0] OFFSET_MSB_DEFAULT = 8'h00;

  // Offset register order: empty low, empty high, full low, full high
  localparam logic [1:0] OFS_EMPTY_LSB = 2'h0;
  localparam logic [1:0] OFS_EMPTY_MSB = 2'h1;
  localparam logic [1:0] OFS_FULL_LSB  = 2'h2;
  localparam logic [1:0] OFS_FULL_MSB  = 2'h3;

  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_OFFSETS = 12'h008;

  localparam int CTRL_EN_BIT    = 0;
  localparam int CTRL_FLUSH_BIT = 1;
  localparam logic CTRL_EN_RESET = 1'b1;

  localparam int ST_FLAGS_LSB = 0;
  localparam int ST_MODE_BIT  = 4;
  localparam int ST_READY_BIT = 5;
  localparam int ST_COUNT_LSB = 16;
  localparam int OFS_FULL_LSB_POS = 16;

  typedef struct packed {
    logic       write_clock;
    logic       read_clock;
    logic       write_enable_one_n;
    logic       write_enable_two_or_load;
    logic       read_enable_one_n;
    logic       read_enable_two_n;
    logic       output_enable_n;
    logic [8:0] write_data_in;
  } pins_t;

  // Enables and output enable start inactive
  localparam pins_t PINS_RESET = 16'h2e00;

  typedef struct packed {
    logic full_flag_n;
    logic almost_full_flag_n;
    logic almost_empty_flag_n;
    logic empty_flag_n;
  } flags_t;

  localparam flags_t FLAGS_RESET = 4'hc;

  typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_OFFSETS, SEL_NONE} reg_sel_t;
  typedef enum logic {PH_WARMUP, PH_RUN} phase_t;

endpackage : dcfifo_pkg
`default_nettype wire

// file: dcfifo_bank.sv
// One FIFO bank: pin sampling, storage, status flags, offset registers and
// an AHB-Lite slave for enable, flush and status.
// Assumes pin clocks well below a quarter of i_mclk so each edge is seen.
//
// Functional notes
// - Full flag low at depth; writes refused
// - Full after exactly depth writes, depth parameter
// - Full flag changes only on write edges; a flush also resets it
// - Empty flag low when count is zero; reads refused
// - Empty flag changes only on read edges; a flush also resets it
// - Almost-full low when count reaches depth minus m
// - Full offset defaults to seven
// - Almost-full changes only on write edges; a flush also resets it
// - Almost-empty low for counts zero to n
// - Empty offset defaults to seven
// - Almost-empty changes only on read edges; a flush also resets it
// - Strap at reset picks second enable or load
// - Data outputs low after reset, tristate by enable
// - Pin clocks may run during reset
// - Full change may slip one write edge
// - Empty change may slip one read edge
// - Partial flags may slip one own edge
// - First word readable one or two read edges
// - Either write enable inactive blocks writes
// - Nine-bit output from this bank's array
// - Write on edge with enable low unless full
// - Read when both enables low unless empty
// - Load mode writes four offsets in rotation
// - Load mode reads offsets in same rotation
`default_nettype none
module dcfifo_bank #(
  parameter int DEPTH = dcfifo_pkg::DEPTH_DEFAULT
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_reset_n,
  input  wire dcfifo_pkg::pins_t    i_pins,
  output var  dcfifo_pkg::flags_t   o_flags,
  output logic [8:0]                o_read_data_out,
  output logic                      o_read_data_oe,
  input  wire logic                 i_hsel,
  input  wire logic [31:0]          i_haddr,
  input  wire logic [1:0]           i_htrans,
  input  wire logic                 i_hwrite,
  input  wire logic [2:0]           i_hsize,
  input  wire logic [31:0]          i_hwdata,
  input  wire logic                 i_hready,
  output logic [31:0]               o_hrdata,
  output logic                      o_hreadyout,
  output logic                      o_hresp
);

  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  function automatic dcfifo_pkg::reg_sel_t decode(input logic [31:0] addr);
    dcfifo_pkg::reg_sel_t sel;
    case (addr[11:0])
      dcfifo_pkg::ADDR_CTRL:    sel = dcfifo_pkg::SEL_CTRL;
      dcfifo_pkg::ADDR_STATUS:  sel = dcfifo_pkg::SEL_STATUS;
      dcfifo_pkg::ADDR_OFFSETS: sel = dcfifo_pkg::SEL_OFFSETS;
      default:                  sel = dcfifo_pkg::SEL_NONE;
    endcase
    return sel;
  endfunction : decode

  // Pin sampling: three flops, a change counts once stages two and three agree
  dcfifo_pkg::pins_t s1_q, s2_q, s3_q, filt_q, filt_d;
  logic              wclk_prev_q, rclk_prev_q;
  logic              wr_edge, rd_edge;

  always_comb begin
    filt_d = (s2_q & s3_q) | (filt_q & (s2_q | s3_q));
  end

  // Sampling keeps running under reset-free operation of the pin clocks
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      s1_q        <= dcfifo_pkg::PINS_RESET;
      s2_q        <= dcfifo_pkg::PINS_RESET;
      s3_q        <= dcfifo_pkg::PINS_RESET;
      filt_q      <= dcfifo_pkg::PINS_RESET;
      wclk_prev_q <= 1'b0;
      rclk_prev_q <= 1'b0;
    end else begin
      s1_q        <= i_pins;
      s2_q        <= s1_q;
      s3_q        <= s2_q;
      filt_q      <= filt_d;
      wclk_prev_q <= filt_q.write_clock;
      rclk_prev_q <= filt_q.read_clock;
    end
  end

  assign wr_edge = filt_q.write_clock & ~wclk_prev_q;
  assign rd_edge = filt_q.read_clock & ~rclk_prev_q;

  // Bus slave state
  logic        en_q, en_d;
  logic        flush_q, flush_d;
  logic        dp_wr_q, dp_wr_d;
  dcfifo_pkg::reg_sel_t dp_sel_q, dp_sel_d;
  logic [31:0] rdata_q, rdata_d;

  // Core state
  dcfifo_pkg::phase_t phase_q, phase_d;
  logic [2:0]         warm_q, warm_d;
  logic               mode_two_q, mode_two_d;
  logic [AW-1:0]      wptr_q, wptr_d, rptr_q, rptr_d;
  logic [CW-1:0]      cnt_q, cnt_d, cnt_nxt;
  dcfifo_pkg::flags_t flags_q, flags_d;
  logic [8:0]         dout_q, dout_d;
  logic [7:0]         ofs_q [dcfifo_pkg::OFFSET_REGS];
  logic [7:0]         ofs_d [dcfifo_pkg::OFFSET_REGS];
  logic [1:0]         sel_q, sel_d;
  logic               push, pop, active;
  logic [15:0]        n_ofs, m_ofs;
  logic [16:0]        fill_plus_m;
  logic [8:0]         mem [DEPTH];

  assign n_ofs = {ofs_q[dcfifo_pkg::OFS_EMPTY_MSB], ofs_q[dcfifo_pkg::OFS_EMPTY_LSB]};
  assign m_ofs = {ofs_q[dcfifo_pkg::OFS_FULL_MSB], ofs_q[dcfifo_pkg::OFS_FULL_LSB]};
  assign active = (phase_q == dcfifo_pkg::PH_RUN) & en_q;

  always_comb begin
    phase_d    = phase_q;
    warm_d     = warm_q;
    mode_two_d = mode_two_q;
    wptr_d     = wptr_q;
    rptr_d     = rptr_q;
    flags_d    = flags_q;
    dout_d     = dout_q;
    ofs_d      = ofs_q;
    sel_d      = sel_q;
    push       = 1'b0;
    pop        = 1'b0;

    case (phase_q)
      dcfifo_pkg::PH_WARMUP: begin
        warm_d = warm_q + 3'h1;
        if (warm_q == dcfifo_pkg::STRAP_WAIT_CYCLES) begin
          // Strap caught after release, once the filtered level is valid
          mode_two_d = filt_q.write_enable_two_or_load;
          phase_d    = dcfifo_pkg::PH_RUN;
        end
      end
      dcfifo_pkg::PH_RUN: begin
        if (active && wr_edge) begin
          if (mode_two_q) begin
            push = ~filt_q.write_enable_one_n & filt_q.write_enable_two_or_load
                   & flags_q.full_flag_n;
          end else if (!filt_q.write_enable_two_or_load) begin
            if (!filt_q.write_enable_one_n) begin
              ofs_d[sel_q] = filt_q.write_data_in[7:0];
              sel_d        = sel_q + 2'h1;
            end
          end else begin
            push = ~filt_q.write_enable_one_n & flags_q.full_flag_n;
          end
        end
        if (active && rd_edge &&
            !filt_q.read_enable_one_n && !filt_q.read_enable_two_n) begin
          if (!mode_two_q && !filt_q.write_enable_two_or_load) begin
            dout_d = {1'b0, ofs_q[sel_q]};
            sel_d  = sel_q + 2'h1;
          end else if (flags_q.empty_flag_n) begin
            // Empty flag gates reads, so a new word waits for a read edge
            pop    = 1'b1;
            dout_d = mem[rptr_q];
          end
        end
      end
      default: phase_d = dcfifo_pkg::PH_WARMUP;
    endcase

    cnt_nxt     = cnt_q + CW'(push) - CW'(pop);
    fill_plus_m = 17'(cnt_nxt) + {1'b0, m_ofs};
    if (push) begin
      wptr_d = wptr_q + AW'(1);
    end
    if (pop) begin
      rptr_d = rptr_q + AW'(1);
    end

    // Opposite-side events since the last own edge show at the next own edge
    if (active && wr_edge) begin
      flags_d.full_flag_n        = (cnt_nxt != CW'(DEPTH));
      flags_d.almost_full_flag_n = (fill_plus_m < 17'(DEPTH));
    end
    if (active && rd_edge) begin
      flags_d.empty_flag_n        = (cnt_nxt != '0);
      flags_d.almost_empty_flag_n = (16'(cnt_nxt) > n_ofs);
    end

    cnt_d = cnt_nxt;
    if (flush_q) begin
      wptr_d  = '0;
      rptr_d  = '0;
      cnt_d   = '0;
      flags_d = dcfifo_pkg::FLAGS_RESET;
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      phase_q    <= dcfifo_pkg::PH_WARMUP;
      warm_q     <= 3'h0;
      mode_two_q <= 1'b0;
      wptr_q     <= '0;
      rptr_q     <= '0;
      cnt_q      <= '0;
      flags_q    <= dcfifo_pkg::FLAGS_RESET;
      dout_q     <= 9'h000;
      sel_q      <= 2'h0;
      ofs_q[dcfifo_pkg::OFS_EMPTY_LSB] <= dcfifo_pkg::OFFSET_LSB_DEFAULT;
      ofs_q[dcfifo_pkg::OFS_EMPTY_MSB] <= dcfifo_pkg::OFFSET_MSB_DEFAULT;
      ofs_q[dcfifo_pkg::OFS_FULL_LSB]  <= dcfifo_pkg::OFFSET_LSB_DEFAULT;
      ofs_q[dcfifo_pkg::OFS_FULL_MSB]  <= dcfifo_pkg::OFFSET_MSB_DEFAULT;
    end else begin
      phase_q    <= phase_d;
      warm_q     <= warm_d;
      mode_two_q <= mode_two_d;
      wptr_q     <= wptr_d;
      rptr_q     <= rptr_d;
      cnt_q      <= cnt_d;
      flags_q    <= flags_d;
      dout_q     <= dout_d;
      sel_q      <= sel_d;
      ofs_q      <= ofs_d;
    end
  end

  // Storage array has no reset; contents are only visible after a write
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wptr_q] <= filt_q.write_data_in;
    end
  end

  assign o_flags         = flags_q;
  assign o_read_data_out = dout_q;
  assign o_read_data_oe  = ~filt_q.output_enable_n;

  // AHB-Lite slave: zero wait states, read data prepared in the address phase
  logic take;
  assign take = i_hsel & i_htrans[1] & i_hready;

  always_comb begin
    en_d     = en_q;
    flush_d  = 1'b0;
    dp_wr_d  = 1'b0;
    dp_sel_d = dp_sel_q;
    rdata_d  = rdata_q;
    if (dp_wr_q && dp_sel_q == dcfifo_pkg::SEL_CTRL) begin
      en_d    = i_hwdata[dcfifo_pkg::CTRL_EN_BIT];
      flush_d = i_hwdata[dcfifo_pkg::CTRL_FLUSH_BIT];
    end
    if (take) begin
      dp_wr_d  = i_hwrite;
      dp_sel_d = decode(i_haddr);
      rdata_d  = 32'h0000_0000;
      if (!i_hwrite) begin
        case (decode(i_haddr))
          dcfifo_pkg::SEL_CTRL: begin
            rdata_d[dcfifo_pkg::CTRL_EN_BIT] = en_q;
          end
          dcfifo_pkg::SEL_STATUS: begin
            rdata_d[dcfifo_pkg::ST_FLAGS_LSB +: 4]  = flags_q;
            rdata_d[dcfifo_pkg::ST_MODE_BIT]        = mode_two_q;
            rdata_d[dcfifo_pkg::ST_READY_BIT]       = (phase_q == dcfifo_pkg::PH_RUN);
            rdata_d[dcfifo_pkg::ST_COUNT_LSB +: CW] = cnt_q;
          end
          dcfifo_pkg::SEL_OFFSETS: begin
            rdata_d = {m_ofs, n_ofs};
          end
          default: rdata_d = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      en_q     <= dcfifo_pkg::CTRL_EN_RESET;
      flush_q  <= 1'b0;
      dp_wr_q  <= 1'b0;
      dp_sel_q <= dcfifo_pkg::SEL_NONE;
      rdata_q  <= 32'h0000_0000;
    end else begin
      en_q     <= en_d;
      flush_q  <= flush_d;
      dp_wr_q  <= dp_wr_d;
      dp_sel_q <= dp_sel_d;
      rdata_q  <= rdata_d;
    end
  end

  assign o_hrdata    = rdata_q;
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

endmodule : dcfifo_bank
`default_nettype wire

// file: dual_clock_fifo_status_flags_asserts.sv
// Concurrent checks on one FIFO bank's pin-side flags and data outputs.
// Assumes each pin clock level lasts at least three i_mclk periods.
`default_nettype none
module fifo_flag_checker #(
  parameter int DEPTH = 256
) (
  input wire logic               i_mclk,
  input wire logic               i_reset_n,
  input wire dcfifo_pkg::pins_t  i_pins,
  input wire dcfifo_pkg::flags_t o_flags,
  input wire logic [8:0]         o_read_data_out,
  input wire logic               o_read_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wcnt_q, wcnt_d, rcnt_q, rcnt_d;
  logic       wclk_q, rclk_q;
  // Cycles since each raw pin clock rose, saturating
  always_comb begin
    wcnt_d = (wcnt_q == 4'hf) ? wcnt_q : wcnt_q + 4'h1;
    rcnt_d = (rcnt_q == 4'hf) ? rcnt_q : rcnt_q + 4'h1;
    if (i_pins.write_clock && !wclk_q) wcnt_d = 4'h0;
    if (i_pins.read_clock && !rclk_q) rcnt_d = 4'h0;
  end
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wcnt_q <= 4'hf;
      rcnt_q <= 4'hf;
      wclk_q <= 1'b1;
      rclk_q <= 1'b1;
    end else begin
      wcnt_q <= wcnt_d;
      rcnt_q <= rcnt_d;
      wclk_q <= i_pins.write_clock;
      rclk_q <= i_pins.read_clock;
    end
  end
  full_on_wclk_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_flags.full_flag_n) |-> wcnt_q inside {[4'h2:4'h9]})
    else $error("full flag moved without a write clock edge");
  afull_on_wclk_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !$stable(o_flags.almost_full_flag_n) |-> wcnt_q > 4'h1 && wcnt_q < 4'ha)
    else $error("almost full moved without a write clock edge");
  empty_on_rclk_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_flags.empty_flag_n) |-> rcnt_q inside {[4'h2:4'h9]})
    else $error("empty flag moved without a read clock edge");
  aempty_on_rclk_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(o_flags.almost_empty_flag_n) || $fell(o_flags.almost_empty_flag_n)
    |-> rcnt_q > 4'h1 && rcnt_q < 4'ha) else $error("almost empty moved off a read edge");
  read_data_gate_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $changed(o_read_data_out) |-> rcnt_q inside {[4'h2:4'h9]}
    && $past(i_pins.read_enable_one_n, 3) == 1'b0) else $error("data moved without a read");
  oe_follows_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $fell(i_pins.output_enable_n) |-> ##[3:8] o_read_data_oe)
    else $error("output enable did not follow its pin");
  full_in_afull_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !o_flags.full_flag_n |-> !o_flags.almost_full_flag_n)
    else $error("full without almost full");
  empty_in_aempty_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    !o_flags.empty_flag_n |-> !o_flags.almost_empty_flag_n)
    else $error("empty without almost empty");
  reset_state_a: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
    $rose(i_reset_n) |-> o_flags == dcfifo_pkg::FLAGS_RESET && o_read_data_out == 9'h000)
    else $error("flags or data wrong after reset");
endmodule : fifo_flag_checker
bind dcfifo_bank fifo_flag_checker #(.DEPTH(DEPTH)) chk (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_pins(i_pins), .o_flags(o_flags),
  .o_read_data_out(o_read_data_out), .o_read_data_oe(o_read_data_oe));
`default_nettype wire

// file: dcfifo_pin_partner.sv
// Writer and reader logic on the pin side of one FIFO bank.
// Assumes calls start just after a rising i_mclk edge, one pulse at a time.
`default_nettype none
module fifo_pin_driver (
  input  wire logic              i_mclk,
  input  wire logic              i_we2,
  input  wire logic              i_re2_off,
  input  wire logic              i_oe_n,
  output wire dcfifo_pkg::pins_t o_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wclk = 1'b0;
  logic       rclk = 1'b0;
  logic       we1_n = 1'b1;
  logic       re_n = 1'b1;
  logic [8:0] data = 9'h0;
  // Second read enable can be held off alone to prove both are needed
  assign o_pins = {wclk, rclk, we1_n, i_we2, re_n, re_n | i_re2_off, i_oe_n, data};
  // Five-cycle levels so the bank's filter sees every edge
  task automatic pulse(input bit wr, input bit en, input logic [8:0] d);
    @(posedge i_mclk);
    if (wr) begin
      we1_n <= !en;
      data  <= d;
    end else begin
      re_n <= !en;
    end
    repeat (5) @(posedge i_mclk);
    if (wr) wclk <= 1'b1;
    else rclk <= 1'b1;
    repeat (5) @(posedge i_mclk);
    wclk <= 1'b0;
    rclk <= 1'b0;
    repeat (5) @(posedge i_mclk);
    we1_n <= 1'b1;
    re_n  <= 1'b1;
    data  <= ~data; // Released bus shows no stale word
  endtask : pulse
endmodule : fifo_pin_driver
`default_nettype wire

// file: dual_clock_fifo_status_flags_tb.sv
// Bench for one FIFO bank: pin traffic via the partner, registers over AHB-Lite.
// Assumes every task is entered just after a rising i_mclk edge.
`default_nettype none
`define CHK(g, e, m) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("[FAIL] %0t %s", $time, m); end end
module dual_clock_fifo_status_flags_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEPTH = 256;
  logic               mclk, reset_n, we2, oe_n, hsel, hwrite, hrdy, hresp, oe, re2_off;
  logic [31:0]        haddr, hwdata, hrdata, rd;
  logic [1:0]         htrans;
  logic [2:0]         hsize;
  logic [8:0]         dout;
  dcfifo_pkg::pins_t  pins;
  dcfifo_pkg::flags_t flags;
  int                 n_errors, n_compared;
  fifo_pin_driver drv (.i_mclk(mclk), .i_we2(we2), .i_re2_off(re2_off), .i_oe_n(oe_n),
    .o_pins(pins));
  dcfifo_bank #(.DEPTH(DEPTH)) uut (.i_mclk(mclk), .i_reset_n(reset_n), .i_pins(pins),
    .o_flags(flags), .o_read_data_out(dout), .o_read_data_oe(oe), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy),
    .o_hresp(hresp));
  initial begin
    mclk = 1'b0;
    forever #(dcfifo_pkg::CLK_PERIOD_NS / 2) mclk = ~mclk;
  end
  function automatic dcfifo_pkg::flags_t exp_flags(input int c);
    return {c < DEPTH, c + 5 < DEPTH, c > 3, c > 0};
  endfunction : exp_flags
  task automatic ahb(input bit wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge mclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask : ahb
  task automatic do_reset(input logic strap);
    reset_n <= 1'b0;
    we2 <= strap;
    // Pin write clock keeps running through reset
    fork
      repeat (10) @(posedge mclk);
      drv.pulse(1'b1, 1'b0, 9'h0);
    join_any
    reset_n <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask : do_reset
  // Active edge first, then an idle edge on the other side to settle its flags
  task automatic step(input bit wr, input logic [8:0] d);
    drv.pulse(wr, 1'b1, d);
    drv.pulse(!wr, 1'b0, 9'h0);
  endtask : step
  task automatic t_reset;
    `CHK(flags, dcfifo_pkg::FLAGS_RESET, "reset flags")
    `CHK({hrdy, hresp}, 2'b10, "okay response")
    `CHK(oe, 1'b0, "oe while disabled")
    oe_n <= 1'b0;
    repeat (8) @(posedge mclk);
    `CHK({oe, dout}, 10'h200, "data low once enabled")
    ahb(1'b0, dcfifo_pkg::ADDR_OFFSETS, 32'h0, rd);
    `CHK(rd, 32'h0007_0007, "default offsets")
    ahb(1'b0, dcfifo_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK(rd[4:0], 5'h0c, "load mode status")
    ahb(1'b0, 12'h00c, 32'h0, rd);
    `CHK(rd, 32'h0, "unmapped read")
    $display("t_reset done");
  endtask : t_reset
  task automatic t_offsets;
    logic [7:0] v[4];
    v = '{8'h03, 8'h00, 8'h05, 8'h00};
    we2 <= 1'b0;
    for (int i = 0; i < 4; i++) drv.pulse(1'b1, 1'b1, {1'b0, v[i]});
    for (int i = 0; i < 4; i++) begin
      drv.pulse(1'b0, 1'b1, 9'h0);
      `CHK(dout, {1'b0, v[i]}, "offset readback")
    end
    we2 <= 1'b1;
    ahb(1'b1, dcfifo_pkg::ADDR_OFFSETS, 32'hffff_ffff, rd);
    ahb(1'b0, dcfifo_pkg::ADDR_OFFSETS, 32'h0, rd);
    `CHK(rd, 32'h0005_0003, "programmed offsets")
    $display("t_offsets done");
  endtask : t_offsets
  task automatic t_fill_drain;
    for (int k = 1; k <= DEPTH + 1; k++) begin
      step(1'b1, 9'(k) ^ 9'h0a5);
      `CHK(flags, exp_flags(k > DEPTH ? DEPTH : k), "fill flags")
    end
    ahb(1'b0, dcfifo_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK(rd[24:16], 9'h100, "count stops at depth")
    for (int j = 1; j <= DEPTH + 1; j++) begin
      step(1'b0, 9'h0);
      `CHK(flags, exp_flags(j > DEPTH ? 0 : DEPTH - j), "drain flags")
      `CHK(dout, 9'(j > DEPTH ? DEPTH : j) ^ 9'h0a5, "drain data")
    end
    $display("t_fill_drain done");
  endtask : t_fill_drain
  task automatic t_two_enable;
    do_reset(1'b1);
    ahb(1'b0, dcfifo_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK(rd[4], 1'b1, "two enable mode")
    we2 <= 1'b0;
    step(1'b1, 9'h1aa);
    `CHK(flags, exp_flags(0), "second enable blocks")
    we2 <= 1'b1;
    drv.pulse(1'b1, 1'b0, 9'h0bb);
    drv.pulse(1'b1, 1'b1, 9'h1aa);
    drv.pulse(1'b0, 1'b1, 9'h0);
    `CHK({flags.empty_flag_n, dout}, 10'h200, "first read edge")
    drv.pulse(1'b0, 1'b1, 9'h0);
    `CHK(dout, 9'h1aa, "word on second edge")
    $display("t_two_enable done");
  endtask : t_two_enable
  // Enable and flush bits, then the second read enable held off alone
  task automatic t_ctrl;
    ahb(1'b0, dcfifo_pkg::ADDR_CTRL, 32'h0, rd);
    `CHK(rd, 32'h0000_0001, "enable after reset")
    ahb(1'b1, dcfifo_pkg::ADDR_CTRL, 32'h0, rd);
    drv.pulse(1'b1, 1'b1, 9'h055);
    ahb(1'b0, dcfifo_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK({rd[24:16], rd[3:0]}, 13'h000c, "disabled bank ignores writes")
    ahb(1'b1, dcfifo_pkg::ADDR_CTRL, 32'h1, rd);
    drv.pulse(1'b1, 1'b1, 9'h055);
    ahb(1'b0, dcfifo_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK({rd[24:16], rd[3:0]}, 13'h001c, "one word held")
    ahb(1'b1, dcfifo_pkg::ADDR_CTRL, 32'h3, rd);
    // Flush clears the count one cycle after its data phase
    @(posedge mclk);
    ahb(1'b0, dcfifo_pkg::ADDR_STATUS, 32'h0, rd);
    `CHK({rd[24:16], rd[3:0]}, 13'h000c, "flush empties bank")
    drv.pulse(1'b1, 1'b1, 9'h066);
    re2_off <= 1'b1;
    drv.pulse(1'b0, 1'b1, 9'h0);
    drv.pulse(1'b0, 1'b1, 9'h0);
    `CHK({flags.empty_flag_n, dout}, 10'h3aa, "one read enable blocks")
    re2_off <= 1'b0;
    drv.pulse(1'b0, 1'b1, 9'h0);
    `CHK(dout, 9'h066, "read with both enables")
    $display("t_ctrl done");
  endtask : t_ctrl
  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  initial begin
    {reset_n, we2, oe_n, hsel, hwrite, re2_off} = 6'h08;
    {haddr, hwdata, htrans, hsize} = {64'h0, 2'h0, 3'h2};
    n_errors = 0;
    n_compared = 0;
    @(posedge mclk);
    do_reset(1'b0);
    t_reset;
    t_offsets;
    t_fill_drain;
    t_two_enable;
    t_ctrl;
    conclude;
  end
  initial begin
    #2_400_000;
    n_errors++;
    conclude;
  end
endmodule : dual_clock_fifo_status_flags_tb
`default_nettype wire
